// ### verilog/uemr_regs.svh
`ifndef UEMR_REGS_SVH
`define UEMR_REGS_SVH

// ----------------------------------------
// I/O space offsets
// ----------------------------------------
`define UEMR_CNT0_ADDR    8'h41
`define UEMR_CNT1_ADDR    8'h42
`define UEMR_CNT2_ADDR    8'h43
`define UEMR_MODE0_ADDR   8'h44
`define UEMR_MODE1_ADDR   8'h45
`define UEMR_MODE2_ADDR   8'h46
`define UEMR_BUF0_BASE    8'h50
`define UEMR_BUF1_BASE    8'h58
`define UEMR_BUF2_BASE    8'h60
`define UEMR_BUF_LAST     8'h67

// ----------------------------------------
// Field positions, reset values, counts
// ----------------------------------------
`define UEMR_STALL_BIT    7
`define UEMR_TOG_BIT      7
`define UEMR_DVAL_BIT     6
`define UEMR_MODE_RESET   4'h0
`define UEMR_CRC_BYTES    4'h2
`define UEMR_MAX_PAYLOAD  4'h8

`endif

// ### verilog/uemr_pkg.sv
package uemr_pkg;

   typedef enum logic [3:0] {
      MODE_DISABLE          = 4'b0000,
      MODE_NAK_IN_OUT       = 4'b0001,
      MODE_STATUS_OUT       = 4'b0010,
      MODE_STALL_IN_OUT     = 4'b0011,
      MODE_RSV_0100         = 4'b0100,
      MODE_RSV_0101         = 4'b0101,
      MODE_STATUS_IN        = 4'b0110,
      MODE_RSV_0111         = 4'b0111,
      MODE_NAK_OUT          = 4'b1000,
      MODE_ACK_OUT          = 4'b1001,
      MODE_RSV_1010         = 4'b1010,
      MODE_ACK_OUT_STAT_IN  = 4'b1011,
      MODE_NAK_IN           = 4'b1100,
      MODE_ACK_IN           = 4'b1101,
      MODE_RSV_1110         = 4'b1110,
      MODE_ACK_IN_STAT_OUT  = 4'b1111
   } uemr_mode_t;

   typedef enum logic [1:0] {
      TOK_SETUP = 2'b00,
      TOK_IN    = 2'b01,
      TOK_OUT   = 2'b10
   } uemr_tok_t;

   typedef enum logic [2:0] {
      RESP_IGNORE   = 3'b000,
      RESP_ACK      = 3'b001,
      RESP_NAK      = 3'b010,
      RESP_STALL    = 3'b011,
      RESP_TX_COUNT = 3'b100,
      RESP_TX_ZERO  = 3'b101
   } uemr_resp_t;

   typedef struct packed {
      logic [1:0] ep;
      uemr_tok_t  kind;
      logic [3:0] rx_len;
      logic       rx_ok;
      logic       rx_toggle;
   } uemr_token_t;

   typedef struct packed {
      uemr_resp_t kind;
      logic [1:0] ep;
      logic [3:0] tx_count;
      logic       tx_toggle;
   } uemr_answer_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } uemr_io_t;

   typedef struct packed {
      logic       we;
      logic [1:0] ep;
      logic [2:0] idx;
      logic [7:0] data;
   } uemr_eng_buf_t;

   typedef struct packed {
      logic       stall;
      logic       ackd;
      uemr_mode_t mode;
      logic       tog;
      logic       dval;
      logic [3:0] count;
   } uemr_ep_t;

   typedef struct packed {
      uemr_ep_t [2:0] ep;
      logic           ans_valid;
      uemr_answer_t   ans;
      logic [7:0]     io_rdata;
      logic [7:0]     eng_rdata;
   } uemr_state_t;

   typedef struct packed {
      logic [7:0][7:0] mem;
   } uemr_buf_state_t;

endpackage

// ### verilog/uemr_buffer.sv
`timescale 1ns/1ps

module uemr_buffer import uemr_pkg::*; (
   input  wire logic       i_clk,
   input  wire logic       i_ce,
   input  wire logic       i_we,
   input  wire logic [2:0] i_idx,
   input  wire logic [7:0] i_wdata,
   input  wire logic [2:0] i_ra,
   input  wire logic [2:0] i_rb,
   output logic      [7:0] o_ra,
   output logic      [7:0] o_rb
);

   uemr_buf_state_t s;
   uemr_buf_state_t next_s;

   always_comb begin
      next_s = s;
      if (i_we) begin
         next_s.mem[i_idx] = i_wdata;
      end
   end

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   // No reset: content is undefined until written
   always_ff @(posedge i_clk) begin
      if (i_ce) begin
         s <= next_s;
      end
   end

   assign o_ra = s.mem[i_ra];
   assign o_rb = s.mem[i_rb];

endmodule

// ### verilog/uemr_decoder.sv
`timescale 1ns/1ps
`include "uemr_regs.svh"

module uemr_decoder import uemr_pkg::*; (
   input  wire uemr_mode_t  i_mode,
   input  wire logic        i_stall,
   input  wire uemr_token_t i_tok,
   output uemr_resp_t       o_resp
);

   logic rx_good;
   logic check_ok;
   logic ctrl;

   // Oversize or corrupt data phases are never answered
   assign rx_good  = i_tok.rx_ok && (i_tok.rx_len <= `UEMR_MAX_PAYLOAD);
   assign check_ok = rx_good && (i_tok.rx_len == 4'h0) && i_tok.rx_toggle;
   assign ctrl     = i_mode inside {MODE_NAK_IN_OUT, MODE_STATUS_OUT, MODE_STALL_IN_OUT,
                                    MODE_STATUS_IN, MODE_ACK_OUT_STAT_IN,
                                    MODE_ACK_IN_STAT_OUT};

   always_comb begin
      o_resp = RESP_IGNORE;
      if (i_tok.kind == TOK_SETUP) begin
         o_resp = (ctrl && rx_good) ? RESP_ACK : RESP_IGNORE;
      end else if (i_tok.kind == TOK_IN) begin
         unique case (i_mode)
            MODE_NAK_IN_OUT:      o_resp = RESP_NAK;
            MODE_STATUS_OUT:      o_resp = RESP_STALL;
            MODE_STALL_IN_OUT:    o_resp = RESP_STALL;
            MODE_STATUS_IN:       o_resp = RESP_TX_ZERO;
            MODE_ACK_OUT_STAT_IN: o_resp = RESP_TX_ZERO;
            MODE_ACK_IN_STAT_OUT: o_resp = RESP_TX_COUNT;
            MODE_NAK_IN:          o_resp = RESP_NAK;
            MODE_ACK_IN:          o_resp = i_stall ? RESP_STALL : RESP_TX_COUNT;
            default:              o_resp = RESP_IGNORE;
         endcase
      end else if (i_tok.kind == TOK_OUT && rx_good) begin
         unique case (i_mode)
            MODE_NAK_IN_OUT:      o_resp = RESP_NAK;
            MODE_STATUS_OUT:      o_resp = check_ok ? RESP_ACK : RESP_STALL;
            MODE_STALL_IN_OUT:    o_resp = RESP_STALL;
            MODE_STATUS_IN:       o_resp = RESP_STALL;
            MODE_ACK_OUT_STAT_IN: o_resp = RESP_ACK;
            MODE_ACK_IN_STAT_OUT: o_resp = check_ok ? RESP_ACK : RESP_STALL;
            MODE_NAK_OUT:         o_resp = RESP_NAK;
            MODE_ACK_OUT:         o_resp = i_stall ? RESP_STALL : RESP_ACK;
            default:              o_resp = RESP_IGNORE;
         endcase
      end
   end

endmodule

// ### verilog/uemr_responder.sv
`timescale 1ns/1ps
`include "uemr_regs.svh"

module uemr_responder import uemr_pkg::*; (
   input  wire logic          i_clk,
   input  wire logic          i_resetn,
   input  wire logic          i_ce,
   input  wire uemr_io_t      i_io,
   output logic         [7:0] o_io_rdata,
   input  wire logic          i_tok_valid,
   input  wire uemr_token_t   i_tok,
   output logic               o_ans_valid,
   output uemr_answer_t       o_ans,
   input  wire logic          i_host_ack,
   input  wire uemr_eng_buf_t i_eng_buf,
   input  wire logic    [1:0] i_eng_rd_ep,
   input  wire logic    [2:0] i_eng_rd_idx,
   output logic         [7:0] o_eng_rdata
);

   localparam logic [7:0] MODE_ADDR [3] = '{`UEMR_MODE0_ADDR, `UEMR_MODE1_ADDR,
                                            `UEMR_MODE2_ADDR};
   localparam logic [7:0] CNT_ADDR  [3] = '{`UEMR_CNT0_ADDR, `UEMR_CNT1_ADDR,
                                            `UEMR_CNT2_ADDR};

   uemr_state_t      s;
   uemr_state_t      next_s;
   uemr_resp_t       resp;
   uemr_ep_t         cur;
   logic       [1:0] sel;
   logic             tok_hit;
   logic       [2:0] eng_wr;
   uemr_mode_t [2:0] eng_mode;
   logic             upd;
   logic             fw_in_buf;
   logic       [7:0] fw_off;
   logic       [2:0] b_eng;
   logic       [2:0] b_fw;
   logic [2:0][7:0]  fw_rd;
   logic [2:0][7:0]  eng_rd;
   logic             rx_good;

   // ----------------------------------------
   // Token decode
   // ----------------------------------------
   assign sel     = (i_tok.ep == 2'h3) ? 2'h0 : i_tok.ep;
   assign cur     = s.ep[sel];
   assign tok_hit = i_ce && i_tok_valid && (i_tok.ep != 2'h3);
   assign rx_good = i_tok.rx_ok && (i_tok.rx_len <= `UEMR_MAX_PAYLOAD);

   uemr_decoder u_dec (
      .i_mode  (cur.mode),
      .i_stall (cur.stall),
      .i_tok   (i_tok),
      .o_resp  (resp)
   );

   // ----------------------------------------
   // Engine mode writes
   // ----------------------------------------
   always_comb begin
      eng_wr   = 3'b000;
      eng_mode = '{default: MODE_DISABLE};
      if (i_ce && i_host_ack && s.ans.kind == RESP_TX_COUNT && s.ans.ep != 2'h3
          && s.ep[s.ans.ep].mode == MODE_ACK_IN && !s.ep[s.ans.ep].stall) begin
         eng_wr[s.ans.ep]   = 1'b1;
         eng_mode[s.ans.ep] = MODE_NAK_IN;
      end
      if (tok_hit && resp == RESP_ACK) begin
         if (i_tok.kind == TOK_SETUP) begin
            eng_wr[sel]   = 1'b1;
            eng_mode[sel] = MODE_NAK_IN_OUT;
         end else if (cur.mode == MODE_ACK_OUT) begin
            eng_wr[sel]   = 1'b1;
            eng_mode[sel] = MODE_NAK_OUT;
         end
      end
   end

   // One update strobe shared by both data endpoints
   assign upd = eng_wr[1] | eng_wr[2];

   // ----------------------------------------
   // Buffers
   // ----------------------------------------
   assign fw_off    = i_io.addr - `UEMR_BUF0_BASE;
   assign fw_in_buf = (i_io.addr >= `UEMR_BUF0_BASE) && (i_io.addr <= `UEMR_BUF_LAST);

   for (genvar g = 0; g < 3; g++) begin : g_buf
      assign b_eng[g] = i_eng_buf.we && (i_eng_buf.ep == 2'(g));
      assign b_fw[g]  = i_io.wr && fw_in_buf && (fw_off[4:3] == 2'(g));
      // Engine data wins a same-cycle collision on one buffer
      uemr_buffer u_buf (
         .i_clk   (i_clk),
         .i_ce    (i_ce),
         .i_we    (b_eng[g] | b_fw[g]),
         .i_idx   (b_eng[g] ? i_eng_buf.idx : fw_off[2:0]),
         .i_wdata (b_eng[g] ? i_eng_buf.data : i_io.wdata),
         .i_ra    (fw_off[2:0]),
         .i_rb    (i_eng_rd_idx),
         .o_ra    (fw_rd[g]),
         .o_rb    (eng_rd[g])
      );
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_s           = s;
      next_s.ans_valid = 1'b0;
      // Firmware writes first so engine writes below override them
      for (int i = 0; i < 3; i++) begin
         if (i_io.wr && i_io.addr == MODE_ADDR[i]
             && !eng_wr[i] && !(i != 0 && upd)) begin
            next_s.ep[i].stall = i_io.wdata[`UEMR_STALL_BIT];
            next_s.ep[i].ackd  = 1'b0;
            next_s.ep[i].mode  = uemr_mode_t'(i_io.wdata[3:0]);
         end
         if (i_io.wr && i_io.addr == CNT_ADDR[i]) begin
            next_s.ep[i].tog   = i_io.wdata[`UEMR_TOG_BIT];
            next_s.ep[i].dval  = i_io.wdata[`UEMR_DVAL_BIT];
            next_s.ep[i].count = i_io.wdata[3:0];
         end
      end
      if (tok_hit) begin
         next_s.ans_valid     = 1'b1;
         next_s.ans.kind      = resp;
         next_s.ans.ep        = sel;
         next_s.ans.tx_toggle = cur.tog;
         next_s.ans.tx_count  = (resp == RESP_TX_COUNT) ? cur.count : 4'h0;
         if (resp == RESP_ACK) begin
            next_s.ep[sel].count = i_tok.rx_len + `UEMR_CRC_BYTES;
            next_s.ep[sel].tog   = i_tok.rx_toggle;
            next_s.ep[sel].dval  = 1'b1;
            next_s.ep[sel].ackd  = 1'b1;
         end
      end
      if (i_host_ack && s.ans.kind inside {RESP_TX_COUNT, RESP_TX_ZERO}) begin
         next_s.ep[s.ans.ep].ackd = 1'b1;
      end
      for (int i = 0; i < 3; i++) begin
         if (eng_wr[i]) begin
            next_s.ep[i].mode = eng_mode[i];
            next_s.ep[i].ackd = 1'b1;
         end
      end
      if (i_io.rd) begin
         next_s.io_rdata = 8'h00;
         for (int i = 0; i < 3; i++) begin
            if (i_io.addr == MODE_ADDR[i]) begin
               next_s.io_rdata = {s.ep[i].stall, 2'b00, s.ep[i].ackd, s.ep[i].mode};
            end
            if (i_io.addr == CNT_ADDR[i]) begin
               next_s.io_rdata = {s.ep[i].tog, s.ep[i].dval, 2'b00, s.ep[i].count};
            end
         end
         if (fw_in_buf) begin
            next_s.io_rdata = fw_rd[fw_off[4:3]];
         end
      end
      next_s.eng_rdata = (i_eng_rd_ep == 2'h3) ? 8'h00 : eng_rd[i_eng_rd_ep];
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         s <= '0;
      end else if (i_ce) begin
         s <= next_s;
      end
   end

   assign o_io_rdata  = s.io_rdata;
   assign o_ans_valid = s.ans_valid;
   assign o_ans       = s.ans;
   assign o_eng_rdata = s.eng_rdata;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_disable_ignores;
      @(posedge i_clk) disable iff (!i_resetn)
      tok_hit && cur.mode == MODE_DISABLE |=> o_ans_valid && o_ans.kind == RESP_IGNORE;
   endproperty
   a_disable_ignores: assert property (p_disable_ignores)
      else $error("disabled endpoint answered a token");

   property p_stall_in_out;
      @(posedge i_clk) disable iff (!i_resetn)
      tok_hit && cur.mode == MODE_STALL_IN_OUT && (i_tok.kind == TOK_IN
         || (i_tok.kind == TOK_OUT && rx_good)) |=> o_ans.kind == RESP_STALL;
   endproperty
   a_stall_in_out: assert property (p_stall_in_out)
      else $error("stall mode did not stall");

   property p_ack_out_to_nak;
      @(posedge i_clk) disable iff (!i_resetn)
      tok_hit && i_tok.kind == TOK_OUT && rx_good && cur.mode == MODE_ACK_OUT && !cur.stall
      |=> o_ans.kind == RESP_ACK && s.ep[$past(sel)].mode == MODE_NAK_OUT;
   endproperty
   a_ack_out_to_nak: assert property (p_ack_out_to_nak)
      else $error("ack-out did not fall back to nak-out");

   property p_ack_out_stalled;
      @(posedge i_clk) disable iff (!i_resetn)
      // A same-cycle firmware mode write may legally move the mode
      tok_hit && i_tok.kind == TOK_OUT && rx_good && cur.mode == MODE_ACK_OUT && cur.stall
      && !i_io.wr |=> o_ans.kind == RESP_STALL && s.ep[$past(sel)].mode == MODE_ACK_OUT;
   endproperty
   a_ack_out_stalled: assert property (p_ack_out_stalled)
      else $error("stalled ack-out not stalled");

   property p_ack_in_to_nak;
      @(posedge i_clk) disable iff (!i_resetn)
      i_ce && i_host_ack && s.ans.kind == RESP_TX_COUNT && s.ans.ep != 2'h3
      && s.ep[s.ans.ep].mode == MODE_ACK_IN && !s.ep[s.ans.ep].stall
      |=> s.ep[$past(s.ans.ep)].mode == MODE_NAK_IN;
   endproperty
   a_ack_in_to_nak: assert property (p_ack_in_to_nak)
      else $error("ack-in did not fall back to nak-in");

   property p_status_bad_toggle;
      @(posedge i_clk) disable iff (!i_resetn)
      tok_hit && i_tok.kind == TOK_OUT && cur.mode == MODE_STATUS_OUT && i_tok.rx_ok
      && i_tok.rx_len == 4'h0 && !i_tok.rx_toggle |=> o_ans.kind == RESP_STALL;
   endproperty
   a_status_bad_toggle: assert property (p_status_bad_toggle)
      else $error("status check accepted toggle 0");

   property p_tx_count;
      @(posedge i_clk) disable iff (!i_resetn)
      tok_hit && resp == RESP_TX_COUNT |=> o_ans_valid && o_ans.tx_count == $past(cur.count);
   endproperty
   a_tx_count: assert property (p_tx_count)
      else $error("transmit count differs from byte count");

   property p_rx_count;
      @(posedge i_clk) disable iff (!i_resetn)
      tok_hit && resp == RESP_ACK && i_tok.kind != TOK_IN
      |=> s.ep[$past(sel)].count == $past(i_tok.rx_len) + 4'h2 && s.ep[$past(sel)].dval;
   endproperty
   a_rx_count: assert property (p_rx_count)
      else $error("received count not bytes plus two");

   property p_engine_wins;
      @(posedge i_clk) disable iff (!i_resetn)
      i_ce && i_io.wr && i_io.addr == `UEMR_MODE1_ADDR && eng_wr[1]
      |=> s.ep[1].mode == $past(eng_mode[1]);
   endproperty
   a_engine_wins: assert property (p_engine_wins)
      else $error("firmware overrode engine mode write");

   property p_shared_block;
      @(posedge i_clk) disable iff (!i_resetn)
      i_ce && i_io.wr && i_io.addr == `UEMR_MODE2_ADDR && eng_wr[1] && !eng_wr[2]
      |=> s.ep[2] == $past(s.ep[2]);
   endproperty
   a_shared_block: assert property (p_shared_block)
      else $error("firmware write passed shared update strobe");

   property p_nak_in;
      @(posedge i_clk) disable iff (!i_resetn)
      tok_hit && i_tok.kind == TOK_IN && cur.mode == MODE_NAK_IN
      |=> o_ans_valid && o_ans.kind == RESP_NAK;
   endproperty
   a_nak_in: assert property (p_nak_in)
      else $error("nak-in mode did not nak an IN");

   property p_ack_in_stalled;
      @(posedge i_clk) disable iff (!i_resetn)
      tok_hit && i_tok.kind == TOK_IN && cur.mode == MODE_ACK_IN && cur.stall
      |=> o_ans_valid && o_ans.kind == RESP_STALL;
   endproperty
   a_ack_in_stalled: assert property (p_ack_in_stalled)
      else $error("stalled ack-in not stalled");

   property p_reserved_ignores;
      @(posedge i_clk) disable iff (!i_resetn)
      tok_hit && cur.mode inside {MODE_RSV_0100, MODE_RSV_0101, MODE_RSV_0111,
                                  MODE_RSV_1010, MODE_RSV_1110}
      |=> o_ans_valid && o_ans.kind == RESP_IGNORE;
   endproperty
   a_reserved_ignores: assert property (p_reserved_ignores)
      else $error("reserved mode answered a token");

endmodule

// ### testbench/uemr_host_model.sv
`timescale 1ns/1ps

module uemr_host_model import uemr_pkg::*; (
   input  wire logic         i_clk,
   input  wire logic         i_ans_valid,
   input  wire uemr_answer_t i_ans,
   output logic              o_tok_valid,
   output uemr_token_t       o_tok,
   output logic              o_host_ack
);
   uemr_token_t tok_q;

   // Released fields show the inverse so stale values never pass as valid
   assign o_tok = o_tok_valid ? tok_q : ~tok_q;

   initial begin
      o_tok_valid = 1'b0;
      o_host_ack  = 1'b0;
      tok_q       = '0;
   end

   task automatic send(input uemr_token_t t, output logic got, output uemr_answer_t a);
      @(posedge i_clk);
      o_tok_valid <= 1'b1;
      tok_q       <= t;
      @(posedge i_clk);
      o_tok_valid <= 1'b0;
      #1;
      got = i_ans_valid;
      a   = i_ans;
   endtask

   // Only after a data answer and before the next token
   task automatic ack();
      @(posedge i_clk);
      o_host_ack <= 1'b1;
      @(posedge i_clk);
      o_host_ack <= 1'b0;
   endtask
endmodule

// ### testbench/uemr_responder_bench.sv
`timescale 1ns/1ps

module uemr_responder_bench import uemr_pkg::*;;
   logic          clk, rstn, ce, tok_valid, host_ack, ans_valid, got;
   logic    [7:0] io_rdata, eng_rdata;
   uemr_io_t      io;
   uemr_token_t   tok;
   uemr_answer_t  ans, a;
   uemr_eng_buf_t eng_buf;
   logic    [1:0] rd_ep;
   logic    [2:0] rd_idx;
   int            miscompares, checked, cycles;

   uemr_responder i_uemr_responder (.i_clk(clk), .i_resetn(rstn), .i_ce(ce), .i_io(io),
      .o_io_rdata(io_rdata), .i_tok_valid(tok_valid), .i_tok(tok), .o_ans_valid(ans_valid),
      .o_ans(ans), .i_host_ack(host_ack), .i_eng_buf(eng_buf), .i_eng_rd_ep(rd_ep),
      .i_eng_rd_idx(rd_idx), .o_eng_rdata(eng_rdata));
   uemr_host_model i_uemr_host_model (.i_clk(clk), .i_ans_valid(ans_valid), .i_ans(ans),
      .o_tok_valid(tok_valid), .o_tok(tok), .o_host_ack(host_ack));

   // ----------------------------------------
   // Checking and bus tasks
   // ----------------------------------------
   task automatic close_out();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic cmp8(input logic [7:0] g, input logic [7:0] e, input string what);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, g, e);
      end
   endtask

   task automatic cmp_ans(input uemr_answer_t g, input uemr_answer_t e);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED at %0t: answer got %h exp %h", $time, g, e);
      end
   endtask

   task automatic io_wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge clk);
      io <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: d};
      @(posedge clk);
      io <= '0;
   endtask

   task automatic rd_chk(input logic [7:0] ad, input logic [7:0] e, input string what);
      @(posedge clk);
      io <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
      @(posedge clk);
      io <= '0;
      #1;
      cmp8(io_rdata, e, what);
   endtask

   function automatic uemr_resp_t exp_resp(input logic [3:0] m, input logic s,
                                           input logic [1:0] k, input logic g);
      exp_resp = RESP_IGNORE;
      if (k == 2'b00) begin
         if (m inside {4'h1, 4'h2, 4'h3, 4'h6, 4'hB, 4'hF}) exp_resp = RESP_ACK;
      end else if (k == 2'b01) begin
         case (m)
            4'h1, 4'hC: exp_resp = RESP_NAK;
            4'h2, 4'h3: exp_resp = RESP_STALL;
            4'h6, 4'hB: exp_resp = RESP_TX_ZERO;
            4'hF:       exp_resp = RESP_TX_COUNT;
            4'hD:       exp_resp = s ? RESP_STALL : RESP_TX_COUNT;
            default:    exp_resp = RESP_IGNORE;
         endcase
      end else begin
         case (m)
            4'h1, 4'h8: exp_resp = RESP_NAK;
            4'h3, 4'h6: exp_resp = RESP_STALL;
            4'hB:       exp_resp = RESP_ACK;
            4'h2, 4'hF: exp_resp = g ? RESP_ACK : RESP_STALL;
            4'h9:       exp_resp = s ? RESP_STALL : RESP_ACK;
            default:    exp_resp = RESP_IGNORE;
         endcase
      end
   endfunction

   task automatic trial(input logic [3:0] m, input logic s, input logic [1:0] k,
                        input logic g);
      uemr_token_t  t;
      uemr_answer_t e;
      logic   [1:0] ep;
      logic   [3:0] nm;
      logic   [7:0] cnt;
      ep = s ? 2'd1 : 2'(m % 3);
      t = '{ep: ep, kind: uemr_tok_t'(k), rx_len: (k == 2'b00) ? 4'h8 : 4'h0, rx_ok: 1'b1,
            rx_toggle: g};
      e = '{kind: exp_resp(m, s, k, g), ep: ep, tx_count: 4'h0, tx_toggle: 1'b1};
      if (e.kind == RESP_TX_COUNT) e.tx_count = 4'h5;
      cnt = (e.kind == RESP_ACK) ? {g, 1'b1, 2'b00, t.rx_len + 4'h2} : 8'h85;
      nm = (e.kind == RESP_ACK && k == 2'b00) ? 4'h1 : m;
      if (e.kind == RESP_ACK && m == 4'h9) nm = 4'h8;
      io_wr(8'h44 + 8'(ep), {s, 3'b000, m});
      io_wr(8'h41 + 8'(ep), 8'h85);
      i_uemr_host_model.send(t, got, a);
      cmp8({7'h00, got}, 8'h01, "answer strobe");
      cmp_ans(a, e);
      rd_chk(8'h44 + 8'(ep), {s, 2'b00, e.kind == RESP_ACK, nm}, "mode");
      rd_chk(8'h41 + 8'(ep), cnt, "count");
      if (m == 4'hD && !s && k == 2'b01) begin
         i_uemr_host_model.ack();
         rd_chk(8'h45, 8'h1C, "mode after host ack");
      end
   endtask

   // ----------------------------------------
   // Clock and timeout
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         close_out();
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      io = '0;
      eng_buf = '0;
      rd_ep = 2'd0;
      rd_idx = 3'd0;
      miscompares = 0;
      checked = 0;
      cycles = 0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      for (int r = 8'h40; r < 8'h47; r++) rd_chk(8'(r), 8'h00, "reset value");
      for (int m = 0; m < 16; m++)
         for (int s = 0; s < 2; s++)
            for (int k = 0; k < 3; k++)
               for (int g = 0; g < 2; g++)
                  if (s == 0 || m == 9 || m == 13) trial(4'(m), 1'(s), 2'(k), 1'(g));
      // Bad data, oversize and foreign endpoint
      io_wr(8'h45, 8'h0B);
      i_uemr_host_model.send('{ep: 2'd1, kind: TOK_OUT, rx_len: 4'h0, rx_ok: 1'b0,
                               rx_toggle: 1'b1}, got, a);
      cmp8({5'h00, a.kind}, {5'h00, RESP_IGNORE}, "bad data");
      i_uemr_host_model.send('{ep: 2'd1, kind: TOK_OUT, rx_len: 4'h9, rx_ok: 1'b1,
                               rx_toggle: 1'b1}, got, a);
      cmp8({5'h00, a.kind}, {5'h00, RESP_IGNORE}, "oversize");
      i_uemr_host_model.send('{ep: 2'd3, kind: TOK_OUT, rx_len: 4'h0, rx_ok: 1'b1,
                               rx_toggle: 1'b1}, got, a);
      cmp8({7'h00, got}, 8'h00, "foreign endpoint");
      rd_chk(8'h45, 8'h0B, "mode kept");
      // Engine mode write against firmware writes in the same cycle
      for (int w = 0; w < 2; w++) begin
         io_wr(8'h46, 8'h08);
         io_wr(8'h45, 8'h09);
         fork
            i_uemr_host_model.send('{ep: 2'd1, kind: TOK_OUT, rx_len: 4'h3, rx_ok: 1'b1,
                                     rx_toggle: 1'b0}, got, a);
            io_wr(w ? 8'h45 : 8'h46, 8'h0C);
         join
         rd_chk(8'h45, 8'h18, "engine wins");
         rd_chk(8'h46, 8'h08, "shared strobe");
         rd_chk(8'h42, 8'h45, "received count");
         io_wr(8'h46, 8'h0C);
         rd_chk(8'h46, 8'h0C, "rewrite");
      end
      // Low clock enable must freeze a firmware write
      @(posedge clk);
      ce <= 1'b0;
      io_wr(8'h46, 8'h01);
      ce <= 1'b1;
      rd_chk(8'h46, 8'h0C, "frozen write");
      // Buffers through both ports
      for (int i = 0; i < 24; i++) io_wr(8'h50 + 8'(i), 8'hC0 ^ 8'(i));
      for (int i = 0; i < 24; i++) begin
         rd_chk(8'h50 + 8'(i), 8'hC0 ^ 8'(i), "buffer io");
         @(posedge clk);
         rd_ep <= 2'(i / 8);
         rd_idx <= 3'(i % 8);
         @(posedge clk);
         #1;
         cmp8(eng_rdata, 8'hC0 ^ 8'(i), "buffer engine");
      end
      @(posedge clk);
      eng_buf <= '{we: 1'b1, ep: 2'd2, idx: 3'd7, data: 8'h5A};
      @(posedge clk);
      eng_buf <= '0;
      rd_chk(8'h67, 8'h5A, "engine write");
      io_wr(8'h68, 8'hFF);
      rd_chk(8'h68, 8'h00, "unmapped");
      rd_chk(8'h4F, 8'h00, "unmapped");
      close_out();
   end
endmodule
